// ---- hdl/flash_cmd_pkg.sv ----
package flash_cmd_pkg;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_VOL_ENABLE    = 8'h50;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS1  = 8'h05;
    localparam logic [7:0] OP_READ_STATUS2  = 8'h35;
    localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
    localparam logic [7:0] OP_READ          = 8'h03;
    localparam logic [7:0] OP_FAST_READ     = 8'h0b;
    localparam logic [7:0] OP_DUAL_READ     = 8'h3b;
    localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG     = 8'h32;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE    = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE2   = 8'h60;
    localparam logic [7:0] OP_SECREG_ERASE  = 8'h44;
    localparam logic [7:0] OP_SECREG_PROG   = 8'h42;

    // ------------------------------------------------------------------
    // Status layout: one = {guard_lo, sector, tb, block[2:0], wel, busy}
    // two = {suspend, invert, lock[3:0], quad, guard_hi}
    // ------------------------------------------------------------------
    localparam int         S1_BUSY        = 0;
    localparam int         S1_WEL         = 1;
    localparam logic [7:0] S1_WR_MASK     = 8'hfc;
    localparam logic [7:0] S2_WR_MASK     = 8'h7f;
    localparam logic [7:0] S2_LOCK_MASK   = 8'h3c;
    localparam logic [7:0] S2_SHORT_CLR   = 8'h43;
    localparam logic [7:0] S2_VOL_KEEP    = 8'h3d;
    localparam logic [7:0] STATUS_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // Frame bit counts and lane timing
    // ------------------------------------------------------------------
    localparam logic [5:0] CODE_BITS      = 6'd8;
    localparam logic [5:0] ADDR_END_BITS  = 6'd32;
    localparam logic [5:0] DUMMY_END_BITS = 6'd40;
    localparam logic [5:0] SW_SHORT_BITS  = 6'd16;
    localparam logic [5:0] SW_LONG_BITS   = 6'd24;
    localparam logic [5:0] NBITS_MAX      = 6'd63;
    localparam logic [2:0] LAST_SINGLE    = 3'd7;
    localparam logic [2:0] LAST_DUAL      = 3'd3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 20;
    localparam int STATUS_WRITE_TIME_NS   = 10000000;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SW_BUSY = 2'b10} sys_state_t;
    typedef enum logic [2:0] {OUT_OFF = 3'b001, OUT_SINGLE = 3'b010, OUT_DUAL = 3'b100} out_mode_t;

endpackage

// ---- hdl/flash_cmd_seq.sv ----
`timescale 1ns/100ps
module flash_cmd_seq #(
    parameter int STATUS_WRITE_TIME = flash_cmd_pkg::STATUS_WRITE_TIME_NS
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        spi_clk,
    input  wire logic        cs_n,
    input  wire logic        serial_in,
    output wire logic        lane_zero_out,
    output wire logic        lane_zero_oe_n,
    output wire logic        lane_one_out,
    output wire logic        lane_one_oe_n,
    output wire logic [23:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    output      logic        array_cmd_start,
    output      logic [7:0]  array_cmd_code,
    input  wire logic        array_busy,
    input  wire logic        array_cmd_done
);
    import flash_cmd_pkg::*;

    // Least one cycle, longest time rounds down
    localparam int SW_CYCLES = (STATUS_WRITE_TIME < CLK_PERIOD_NS) ? 1 : STATUS_WRITE_TIME / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Bits clocked in before the first output edge; zero never matches
    function automatic logic [5:0] lead_bits(input logic [7:0] code, input logic busy);
        logic [5:0] n;
        n = 6'd0;
        if (code == OP_READ_STATUS1 || code == OP_READ_STATUS2) begin
            n = CODE_BITS;
        end else if (busy) begin
            n = 6'd0;
        end else if (code == OP_READ) begin
            n = ADDR_END_BITS;
        end else if (code == OP_FAST_READ || code == OP_DUAL_READ) begin
            n = DUMMY_END_BITS;
        end
        return n;
    endfunction

    // Replace only the writable positions
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction

    function automatic logic is_array_op(input logic [7:0] code);
        return code == OP_PAGE_PROG || code == OP_QUAD_PROG || code == OP_SECTOR_ERASE
            || code == OP_BLOCK32_ERASE || code == OP_BLOCK64_ERASE || code == OP_CHIP_ERASE
            || code == OP_CHIP_ERASE2 || code == OP_SECREG_ERASE || code == OP_SECREG_PROG;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        fresh_q;
    logic [5:0]  cnt_q;
    logic [23:0] shift_q;
    logic [7:0]  cmd_q;
    logic [23:0] addr_q;
    out_mode_t   mode_q;
    logic [2:0]  bit_q;
    logic [7:0]  out_q;
    logic [23:0] rd_addr_q;
    logic [15:0] stat_m_q;
    logic [15:0] stat_l_q;
    logic [7:0]  next_byte;

    logic        cs_m_q;
    logic        cs_s_q;
    logic        cs_d_q;
    logic        frame_end;
    sys_state_t  state_q;
    logic [23:0] timer_q;
    logic        wel_q;
    logic        arm_q;
    logic [7:0]  status_one_q;
    logic [7:0]  status_two_q;
    logic        sw_busy;
    logic        busy;
    logic [7:0]  status_one_rd;
    logic        sw_ok;
    logic        sw_long;
    logic        sw_vol;
    logic        sw_start_nv;
    logic        sw_start_vol;
    logic [7:0]  sw_d1;
    logic [7:0]  sw_d2;

    // ------------------------------------------------------------------
    // Link side: command intake on rising serial clock
    // ------------------------------------------------------------------

    // Marks the first edge of a frame; select high presets it
    always_ff @(posedge spi_clk or negedge reset_n or posedge cs_n) begin
        if (!reset_n) begin
            fresh_q <= 1'b1;
        end else if (cs_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // Bit count, shifter, code and address capture
    // Not cleared by select, so the system side can read them after the frame
    always_ff @(posedge spi_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q   <= 6'd0;
            shift_q <= 24'h000000;
            cmd_q   <= 8'h00;
            addr_q  <= 24'h000000;
        end else if (!cs_n) begin
            shift_q <= {shift_q[22:0], serial_in};
            if (fresh_q) begin
                cnt_q <= 6'd1;
            end else if (cnt_q != NBITS_MAX) begin
                cnt_q <= cnt_q + 6'd1;
            end
            if (!fresh_q && cnt_q == CODE_BITS - 6'd1) begin
                cmd_q <= {shift_q[6:0], serial_in};
            end
            if (!fresh_q && cnt_q == ADDR_END_BITS - 6'd1) begin
                addr_q <= {shift_q[22:0], serial_in};
            end
        end
    end

    // ------------------------------------------------------------------
    // Link side: status into the serial clock domain
    // ------------------------------------------------------------------

    // Each status bit is an independent level, so bitwise syncs suffice;
    // eight edges of code pass before any bit is shifted out
    always_ff @(negedge spi_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_m_q <= 16'h0000;
            stat_l_q <= 16'h0000;
        end else begin
            stat_m_q <= {status_two_q, status_one_rd};
            stat_l_q <= stat_m_q;
        end
    end

    // Next byte to shift: status or the addressed memory byte
    always_comb begin
        if (cmd_q == OP_READ_STATUS1) begin
            next_byte = stat_l_q[7:0];
        end else if (cmd_q == OP_READ_STATUS2) begin
            next_byte = stat_l_q[15:8];
        end else begin
            next_byte = mem_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Link side: output on falling serial clock
    // ------------------------------------------------------------------
    always_ff @(negedge spi_clk or negedge reset_n or posedge cs_n) begin
        if (!reset_n) begin
            mode_q    <= OUT_OFF;
            bit_q     <= 3'd0;
            out_q     <= 8'h00;
            rd_addr_q <= 24'h000000;
        end else if (cs_n) begin
            // Every register here takes the select clear, so none needs an async hold
            mode_q    <= OUT_OFF;
            bit_q     <= 3'd0;
            out_q     <= 8'h00;
            rd_addr_q <= 24'h000000;
        end else begin
            case (mode_q)
                OUT_OFF: begin
                    // Read while busy gets a zero lead and never starts
                    if (cnt_q == lead_bits(cmd_q, stat_l_q[S1_BUSY])) begin
                        mode_q    <= (cmd_q == OP_DUAL_READ) ? OUT_DUAL : OUT_SINGLE;
                        out_q     <= next_byte;
                        rd_addr_q <= addr_q + 24'h000001;
                        bit_q     <= 3'd0;
                    end
                end
                OUT_SINGLE: begin
                    if (bit_q == LAST_SINGLE) begin
                        out_q     <= next_byte;
                        rd_addr_q <= rd_addr_q + 24'h000001;
                        bit_q     <= 3'd0;
                    end else begin
                        out_q <= {out_q[6:0], 1'b0};
                        bit_q <= bit_q + 3'd1;
                    end
                end
                OUT_DUAL: begin
                    if (bit_q == LAST_DUAL) begin
                        out_q     <= next_byte;
                        rd_addr_q <= rd_addr_q + 24'h000001;
                        bit_q     <= 3'd0;
                    end else begin
                        out_q <= {out_q[5:0], 2'b00};
                        bit_q <= bit_q + 3'd1;
                    end
                end
                default: begin
                    mode_q <= OUT_OFF;
                end
            endcase
        end
    end

    // Memory address: captured address until streaming, then the running one
    assign mem_addr       = (mode_q == OUT_OFF) ? addr_q : rd_addr_q;
    // Lane one is the single-lane output; dual puts odd bits here
    assign lane_one_out   = out_q[7];
    assign lane_one_oe_n  = (mode_q == OUT_OFF);
    // Lane zero turns round only in dual mode, after the dummy clocks
    assign lane_zero_out  = out_q[6];
    assign lane_zero_oe_n = (mode_q != OUT_DUAL);

    // ------------------------------------------------------------------
    // System side: end of frame
    // ------------------------------------------------------------------

    // Select crosses by two flops; its rise is the handshake that makes the
    // link capture registers stable, as no serial edges come while high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
        end else begin
            cs_m_q <= cs_n;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
        end
    end

    assign frame_end     = cs_s_q & ~cs_d_q;
    assign sw_busy       = (state_q == ST_SW_BUSY);
    assign busy          = sw_busy | array_busy;
    assign status_one_rd = {status_one_q[7:2], wel_q, busy};

    // Status write decode
    assign sw_long      = (cnt_q == SW_LONG_BITS);
    assign sw_ok        = frame_end && !busy && cmd_q == OP_WRITE_STATUS
                          && (sw_long || cnt_q == SW_SHORT_BITS) && (wel_q || arm_q);
    assign sw_vol       = arm_q && !wel_q;
    assign sw_start_nv  = sw_ok && !sw_vol;
    assign sw_start_vol = sw_ok && sw_vol;
    assign sw_d1        = sw_long ? shift_q[15:8] : shift_q[7:0];
    assign sw_d2        = shift_q[7:0];

    // ------------------------------------------------------------------
    // System side: status bits
    // ------------------------------------------------------------------

    // Applied at frame end for both kinds; volatile lands in one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_one_q <= STATUS_RESET;
            status_two_q <= STATUS_RESET;
        end else if (sw_ok) begin
            status_one_q <= merge(status_one_q, sw_d1, S1_WR_MASK);
            status_two_q <= (sw_long ? merge(status_two_q, sw_d2, S2_WR_MASK)
                                     : (status_two_q & ~S2_SHORT_CLR))
                            | (status_two_q & (sw_vol ? S2_VOL_KEEP : S2_LOCK_MASK));
        end
    end

    // Write latch; set wins over a completion clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wel_q <= 1'b0;
        end else if (frame_end && !busy && cmd_q == OP_WRITE_ENABLE && cnt_q == CODE_BITS) begin
            wel_q <= 1'b1;
        end else if (frame_end && !busy && cmd_q == OP_WRITE_DISABLE && cnt_q == CODE_BITS) begin
            wel_q <= 1'b0;
        end else if ((sw_busy && timer_q == 24'h000000) || array_cmd_done) begin
            wel_q <= 1'b0;
        end
    end

    // Volatile arming; consumed by the status write it enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arm_q <= 1'b0;
        end else if (frame_end && !busy && cmd_q == OP_VOL_ENABLE && cnt_q == CODE_BITS) begin
            arm_q <= 1'b1;
        end else if (frame_end && !busy && cmd_q == OP_WRITE_DISABLE && cnt_q == CODE_BITS) begin
            arm_q <= 1'b0;
        end else if (sw_ok) begin
            arm_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // System side: self-timed status write cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            timer_q <= 24'h000000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (sw_start_nv) begin
                        state_q <= ST_SW_BUSY;
                        timer_q <= 24'(SW_CYCLES - 1);
                    end
                end
                ST_SW_BUSY: begin
                    if (timer_q == 24'h000000) begin
                        state_q <= ST_IDLE;
                    end else begin
                        timer_q <= timer_q - 24'h000001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // System side: hand-off of program and erase commands
    // ------------------------------------------------------------------

    // Refused without the latch; the array logic reports completion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            array_cmd_start <= 1'b0;
            array_cmd_code  <= 8'h00;
        end else begin
            array_cmd_start <= frame_end && !busy && wel_q && is_array_op(cmd_q);
            if (frame_end && is_array_op(cmd_q)) begin
                array_cmd_code <= cmd_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_wel_set;
        @(posedge clk) disable iff (!reset_n)
        frame_end && !busy && cmd_q == OP_WRITE_ENABLE && cnt_q == CODE_BITS |=> wel_q;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("write enable did not set latch");

    property p_wdis;
        @(posedge clk) disable iff (!reset_n)
        frame_end && !busy && cmd_q == OP_WRITE_DISABLE && cnt_q == CODE_BITS |=> !wel_q && !arm_q;
    endproperty
    a_wdis: assert property (p_wdis) else $error("write disable left latch or arm set");

    property p_vol_arm;
        @(posedge clk) disable iff (!reset_n)
        frame_end && !busy && cmd_q == OP_VOL_ENABLE && cnt_q == CODE_BITS |=> arm_q && (wel_q == $past(wel_q));
    endproperty
    a_vol_arm: assert property (p_vol_arm) else $error("volatile enable misbehaved");

    property p_bad_len;
        @(posedge clk) disable iff (!reset_n)
        frame_end && cmd_q == OP_WRITE_STATUS && cnt_q != SW_SHORT_BITS && cnt_q != SW_LONG_BITS
        |=> $stable(status_one_q) && $stable(status_two_q) && !$rose(sw_busy);
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("status write of wrong length ran");

    property p_nv_busy;
        @(posedge clk) disable iff (!reset_n)
        sw_start_nv |=> sw_busy [*4];
    endproperty
    a_nv_busy: assert property (p_nv_busy) else $error("busy not held in status write");

    property p_sw_end;
        @(posedge clk) disable iff (!reset_n)
        $fell(sw_busy) |-> !wel_q;
    endproperty
    a_sw_end: assert property (p_sw_end) else $error("latch not cleared after status write");

    property p_lock;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> ((($past(status_two_q) & ~status_two_q) & S2_LOCK_MASK) == 8'h00);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit fell");

    property p_vol_quiet;
        @(posedge clk) disable iff (!reset_n)
        sw_start_vol |=> !sw_busy && !wel_q ##1 !sw_busy;
    endproperty
    a_vol_quiet: assert property (p_vol_quiet) else $error("volatile write raised busy");

    property p_short_clr;
        @(posedge clk) disable iff (!reset_n)
        sw_ok && !sw_long |=> ((status_two_q & S2_SHORT_CLR & ~($past(sw_vol) ? S2_VOL_KEEP : 8'h00)) == 8'h00);
    endproperty
    a_short_clr: assert property (p_short_clr) else $error("short write kept quad or invert");

    property p_lead;
        @(negedge spi_clk) disable iff (cs_n || !reset_n)
        mode_q != OUT_OFF && $past(mode_q) == OUT_OFF |-> $past(cnt_q) == CODE_BITS
                                                         || $past(cnt_q) == ADDR_END_BITS
                                                         || $past(cnt_q) == DUMMY_END_BITS;
    endproperty
    a_lead: assert property (p_lead) else $error("output started at wrong bit");

    property p_dual_lane;
        @(negedge spi_clk) disable iff (cs_n || !reset_n)
        !lane_zero_oe_n |-> cmd_q == OP_DUAL_READ && cnt_q >= DUMMY_END_BITS;
    endproperty
    a_dual_lane: assert property (p_dual_lane) else $error("lane zero driven outside dual data");

    // Main scenarios
    c_status_read: cover property (@(negedge spi_clk) mode_q == OUT_SINGLE && cmd_q == OP_READ_STATUS1);
    c_nv_write:    cover property (@(posedge clk) disable iff (!reset_n) $fell(sw_busy));
    c_vol_write:   cover property (@(posedge clk) disable iff (!reset_n) sw_start_vol);
    c_dual_read:   cover property (@(negedge spi_clk) mode_q == OUT_DUAL && bit_q == LAST_DUAL);

endmodule // flash_cmd_seq

// ---- tb/flash_array_model.sv ----
`timescale 1ns/100ps
// ----
// Memory array and program engine stand-in
// ----
module flash_array_model (
    input  wire logic        clk,
    input  wire logic [23:0] mem_addr,
    output wire logic [7:0]  mem_rdata,
    input  wire logic        array_cmd_start,
    output wire logic        array_busy,
    output wire logic        array_cmd_done
);
    logic [2:0] cnt_q = 3'h0;
    // Pattern mixes two address bytes so a lost increment shows
    assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5a;
    // Short array cycle after an accepted start
    always @(posedge clk) begin
        cnt_q <= array_cmd_start ? 3'h5 : cnt_q - {2'h0, cnt_q != 3'h0};
    end
    assign array_busy = (cnt_q != 3'h0);
    assign array_cmd_done = (cnt_q == 3'h1);
endmodule // flash_array_model

// ---- tb/serial_flash_status_and_read_cmds_bench.sv ----
`timescale 1ns/100ps
// ----
// Bench
// ----
module serial_flash_status_and_read_cmds_bench;
    logic clk = 0, reset_n = 0, spi_clk = 0, cs_n = 1, serial_in = 0, l0, l0_oe_n, l1, l1_oe_n, st, bz, dn;
    logic [23:0] mem_addr, a;
    logic [7:0] mem_rdata, d1, d2, s1, s2, cc;
    logic [63:0] r1, r0;
    int bad_count = 0, num_checks = 0, seed = 42, drv, dz, starts = 0;
    // System clock
    always #10 clk = ~clk;
    flash_cmd_seq #(.STATUS_WRITE_TIME(4000)) flash_cmd_seq_i (.clk(clk), .reset_n(reset_n), .spi_clk(spi_clk),
        .cs_n(cs_n), .serial_in(serial_in), .lane_zero_out(l0), .lane_zero_oe_n(l0_oe_n), .lane_one_out(l1),
        .lane_one_oe_n(l1_oe_n), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .array_cmd_start(st),
        .array_cmd_code(cc), .array_busy(bz), .array_cmd_done(dn));
    flash_array_model flash_array_model_i (.clk(clk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .array_cmd_start(st), .array_busy(bz), .array_cmd_done(dn));
    // Accepted program and erase hand-offs
    always @(posedge clk) if (st === 1'b1) starts <= starts + 1;
    function automatic logic [7:0] pat(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5a;
    endfunction
    // One frame: n bits sent, then m clocks with lane zero let go; 32 ns link clock runs only here
    task automatic xfer(input logic [63:0] tx, input int n, input int m);
        @(negedge clk) cs_n = 1'b0;
        drv = 0;
        dz = 0;
        for (int i = n + m - 1; i >= 0; i--) begin
            #7 if (i >= m) serial_in = tx[i - m];
            #9 spi_clk = 1'b1;
            r1 = {r1[62:0], l1};
            r0 = {r0[62:0], l0};
            drv = drv + (l1_oe_n === 1'b0);
            dz = dz + (l0_oe_n === 1'b0);
            #8 if (i == m) serial_in = 1'bz;
            #8 spi_clk = 1'b0;
        end
        @(negedge clk) cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // Status read twice over, so the repeat is seen too
    task automatic rds(input logic [7:0] op, input logic [7:0] exp);
        xfer({56'h0, op}, 8, 16);
        chk("status", exp, r1[15:8]);
        chk("status repeat", exp, r1[7:0]);
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #400000 bad_count++;
        wrap_up;
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        rds(8'h05, 8'h00);
        rds(8'h35, 8'h00);
        xfer(64'h06, 8, 0);
        rds(8'h05, 8'h02);
        xfer(64'h50, 8, 0);
        xfer(64'h04, 8, 0);
        rds(8'h05, 8'h00);
        xfer(64'h01ffff, 24, 0);
        rds(8'h05, 8'h00);
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        xfer(64'h06, 8, 0);
        xfer({40'h0, 8'h01, d1, d2}, 24, 0);
        s1 = d1 & 8'hfc;
        s2 = d2 & 8'h7f;
        rds(8'h05, s1 | 8'h03);
        xfer(64'h03000000, 32, 16);
        chk("read while busy", 8'h00, 8'(drv));
        repeat (200) @(negedge clk);
        rds(8'h05, s1);
        rds(8'h35, s2);
        d1 = 8'($random(seed));
        xfer(64'h50, 8, 0);
        xfer({48'h0, 8'h01, d1}, 16, 0);
        s1 = d1 & 8'hfc;
        s2 = s2 & 8'hbd;
        rds(8'h05, s1);
        rds(8'h35, s2);
        xfer(64'h06, 8, 0);
        xfer(64'h01fff, 20, 0);
        rds(8'h05, s1 | 8'h02);
        xfer(64'h01_0000, 24, 0);
        repeat (200) @(negedge clk);
        rds(8'h35, s2 & 8'h3c);
        xfer(64'h20000000, 32, 0);
        chk("refused start", 8'h00, 8'(starts));
        xfer(64'h06, 8, 0);
        xfer(64'hd8000000, 32, 0);
        chk("array start", 8'h01, 8'(starts));
        chk("array code", 8'hd8, cc);
        rds(8'h05, 8'h00);
        a = 24'($random(seed));
        xfer({32'h0, 8'h03, a}, 32, 16);
        chk("read", pat(a), r1[15:8]);
        chk("read next", pat(a + 24'h1), r1[7:0]);
        xfer({24'h0, 8'h0b, a, 8'h00}, 40, 8);
        chk("fast read", pat(a), r1[7:0]);
        chk("lane zero idle", 8'h00, 8'(dz));
        xfer({24'h0, 8'h3b, a, 8'h00}, 40, 4);
        chk("dual read", pat(a), {r1[3], r0[3], r1[2], r0[2], r1[1], r0[1], r1[0], r0[0]});
        chk("lane zero drive", 8'h04, 8'(dz));
        wrap_up;
    end
endmodule // serial_flash_status_and_read_cmds_bench
